// >>> tdsr_pkg.sv
package tdsr_pkg;

  localparam logic [6:0] THERMAL_EVENT_FLAGS_ADDR = 7'h41;
  localparam logic [6:0] DEVICE_INFORMATION_FLAGS_ADDR = 7'h42;
  localparam logic [15:0] REG_RESET_VAL = 16'h0000;

  // Thermal register field positions
  localparam int PREWARN_BIT = 0;
  localparam int LEVEL_ONE_BIT = 1;
  localparam int LEVEL_TWO_BIT = 2;
  localparam int SAFE_STATE_BIT = 3;

  // Device information field positions
  localparam int FAILURE_BIT = 0;
  localparam int INVALID_CMD_BIT = 1;
  localparam int WD_CNT_LO = 2;
  localparam int DEV_MODE_BIT = 4;
  localparam int PRIOR_MODE_LO = 6;
  localparam int CRC_FAIL_BIT = 8;
  localparam int CRC_STAT_BIT = 9;

  localparam logic [1:0] PRIOR_CLEARED = 2'h0;
  localparam logic [1:0] PRIOR_RESTART = 2'h1;
  localparam logic [1:0] PRIOR_SLEEP = 2'h2;
  localparam logic [1:0] WD_CNT_MAX = 2'h3;

  localparam int SAFE_STATE_EVENTS = 16;
  localparam int SAFE_WAIT_S = 64;
  localparam int EVENT_CNT_W = 5;

  // Hardware events, one-cycle pulses unless noted
  typedef struct packed {
    logic prewarn;
    logic level_one;
    logic level_two;
    logic level_two_clear;
    logic wd_expired;
    logic wd_clear;
    logic logic_uv;
    logic failsafe_wake;
    logic sleep_no_wake;
    logic sleep_entry;
    logic crc_fail;
    logic crc_static_seq;
    logic invalid_cmd;
    logic device_fail;
  } tdsr_events_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [15:0] wdata;
  } tdsr_access_t;

  typedef enum logic [1:0] {
    TDSR_RST_NONE,
    TDSR_RST_POR,
    TDSR_RST_SOFT,
    TDSR_RST_RESTART
  } tdsr_rst_t;

endpackage : tdsr_pkg

// >>> tdsr_safe_cnt.sv
`timescale 1ns/1ps
// Counts consecutive level-two shutdowns; safe state past the threshold
module tdsr_safe_cnt #(
  parameter int THRESHOLD = tdsr_pkg::SAFE_STATE_EVENTS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  input wire logic event_in,
  input wire logic break_in,
  output logic safe_out
);
  logic [tdsr_pkg::EVENT_CNT_W-1:0] cnt_ff;
  localparam logic [tdsr_pkg::EVENT_CNT_W-1:0] TH_W =
    tdsr_pkg::EVENT_CNT_W'(THRESHOLD);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
    end else if (clr_in || break_in) begin
      cnt_ff <= '0;
    end else if (event_in && cnt_ff <= TH_W) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Saturates one past threshold, i.e. more than 16 events
  assign safe_out = event_in && (cnt_ff >= TH_W);
endmodule : tdsr_safe_cnt

// >>> tdsr_wd_cnt.sv
`timescale 1ns/1ps
module tdsr_wd_cnt (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  input wire logic fail_in,
  input wire logic auto_clr_in,
  output logic [1:0] cnt_out
);
  logic [1:0] cnt_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
    end else if (clr_in) begin
      cnt_ff <= '0;
    end else if (fail_in && cnt_ff != tdsr_pkg::WD_CNT_MAX) begin
      cnt_ff <= cnt_ff + 2'h1;
    end else if (auto_clr_in && !fail_in) begin
      cnt_ff <= '0;
    end
  end

  assign cnt_out = cnt_ff;
endmodule : tdsr_wd_cnt

// >>> tdsr_status_regs.sv
`timescale 1ns/1ps
// What this block does
// (R1) Thermal register bits 15:4 always read zero.
// (R2) More than 16 consecutive level-two shutdowns set safe flag, 64 s wait.
// (R3) Level-two overtemperature sets bit 2 and requests fail-safe mode.
// (R4) Level-one overtemperature sets bit 1, disables affected module only.
// (R5) Thermal pre-warning sets bit 0.
// (R6) Thermal flags stay set until read-clear or reset.
// (R7) Power-on/soft reset zero both; restart keeps flag bits.
// (R8) Device information bits 15:10 always read zero.
// (R9) Bit 9 shows checksum protection enabled.
// (R10) Bit 8 sets on checksum failure, not on static enable sequence.
// (R11) Prior-mode field 7:6: 00 cleared, 01 restart, 10 sleep.
// (R12) Watchdog, shutdown, undervoltage or fail-safe wake write restart code.
// (R13) Sleep request without wake source also writes restart code.
// (R14) Bit 4 shows software development mode.
// (R15) Bits 3:2 count watchdog failures, saturating at three.
// (R16) Only the watchdog counter is cleared by the device itself.
// (R17) Invalid serial command sets bit 1.
// (R18) Invalid-command flag clears only by a device-information read or a reset.
// (R19) Device failure sets bit 0.
// (R20) Device information read ignores checksum; checksum bits always readable.
// (R21) Read-clear fields return value then clear; others unaffected by reads.
module tdsr_status_regs (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire tdsr_pkg::tdsr_rst_t RST_KIND_IN,
  input wire tdsr_pkg::tdsr_events_t EVENTS_IN,
  input wire tdsr_pkg::tdsr_access_t ACCESS_IN,
  input wire logic ACCESS_CRC_OK_IN,
  input wire logic CRC_ENABLED_IN,
  input wire logic DEV_MODE_IN,
  output logic [15:0] RDATA_OUT,
  output logic RDATA_VALID_OUT,
  output logic ACCESS_REJECT_OUT,
  output logic FAILSAFE_REQ_OUT,
  output logic MODULE_DISABLE_OUT,
  output logic LONG_WAIT_OUT
);

  ////////////////////////////////////////////////////////////////////////
  logic [3:0] therm_ff;
  logic crc_fail_ff;
  logic [1:0] prior_ff;
  logic invalid_ff;
  logic failure_ff;
  logic long_wait_ff;
  logic [1:0] wd_cnt;
  logic safe_evt;
  logic soft_clr;
  logic rd_therm;
  logic rd_dev;
  logic wr_dev;
  logic dev_accept;
  logic restart_evt;

  // Soft reset zeros everything; restart leaves flags alone
  assign soft_clr = (RST_KIND_IN == tdsr_pkg::TDSR_RST_POR) ||
                    (RST_KIND_IN == tdsr_pkg::TDSR_RST_SOFT); // R7

  function automatic logic hit(input tdsr_pkg::tdsr_access_t a,
                               input logic [6:0] addr);
    hit = a.valid && (a.addr == addr);
  endfunction : hit

  // Checksum field ignored for device information reads
  assign dev_accept = hit(ACCESS_IN,
                          tdsr_pkg::DEVICE_INFORMATION_FLAGS_ADDR); // R20
  // Writes to the thermal register must not clear its flags
  assign rd_therm = hit(ACCESS_IN, tdsr_pkg::THERMAL_EVENT_FLAGS_ADDR) &&
                    ACCESS_CRC_OK_IN && !ACCESS_IN.write;
  assign rd_dev = dev_accept && !ACCESS_IN.write;
  assign wr_dev = dev_accept && ACCESS_IN.write;
  assign ACCESS_REJECT_OUT = ACCESS_IN.valid && !ACCESS_CRC_OK_IN &&
                             !dev_accept;

  ////////////////////////////////////////////////////////////////////////
  tdsr_safe_cnt #(
    .THRESHOLD(tdsr_pkg::SAFE_STATE_EVENTS)
  ) u_safe (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .clr_in(soft_clr),
    .event_in(EVENTS_IN.level_two),
    .break_in(EVENTS_IN.level_two_clear),
    .safe_out(safe_evt)
  );

  // Set beats read-clear on every thermal flag
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      therm_ff <= '0;
    end else if (soft_clr) begin
      therm_ff <= '0; // R7
    end else begin
      therm_ff <= (rd_therm ? 4'h0 : therm_ff) | // R21 R6
                  {safe_evt, // R2
                   EVENTS_IN.level_two, // R3
                   EVENTS_IN.level_one, // R4
                   EVENTS_IN.prewarn}; // R5
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      long_wait_ff <= 1'b0;
    end else if (soft_clr || EVENTS_IN.level_two_clear) begin
      long_wait_ff <= 1'b0;
    end else if (safe_evt) begin
      long_wait_ff <= 1'b1; // R2
    end
  end

  // Shutdown consequences, outside this block's timers
  assign FAILSAFE_REQ_OUT = EVENTS_IN.level_two; // R3
  assign MODULE_DISABLE_OUT = EVENTS_IN.level_one; // R4
  assign LONG_WAIT_OUT = long_wait_ff; // R2

  ////////////////////////////////////////////////////////////////////////
  tdsr_wd_cnt u_wd (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .clr_in(soft_clr),
    .fail_in(EVENTS_IN.wd_expired), // R15
    .auto_clr_in(EVENTS_IN.wd_clear), // R16
    .cnt_out(wd_cnt)
  );

  assign restart_evt = EVENTS_IN.wd_expired || EVENTS_IN.level_two ||
                       EVENTS_IN.logic_uv || EVENTS_IN.failsafe_wake || // R12
                       EVENTS_IN.sleep_no_wake; // R13

  // Restart cause wins over sleep and over the clearing access
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      prior_ff <= tdsr_pkg::PRIOR_CLEARED;
    end else if (soft_clr) begin
      prior_ff <= tdsr_pkg::PRIOR_CLEARED;
    end else if (restart_evt) begin
      prior_ff <= tdsr_pkg::PRIOR_RESTART; // R12 R13
    end else if (EVENTS_IN.sleep_entry) begin
      prior_ff <= tdsr_pkg::PRIOR_SLEEP; // R11
    end else if (rd_dev || wr_dev) begin
      prior_ff <= tdsr_pkg::PRIOR_CLEARED; // R11 R21
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      crc_fail_ff <= 1'b0;
      invalid_ff <= 1'b0;
      failure_ff <= 1'b0;
    end else if (soft_clr) begin
      crc_fail_ff <= 1'b0;
      invalid_ff <= 1'b0;
      failure_ff <= 1'b0;
    end else begin
      crc_fail_ff <= (crc_fail_ff && !rd_dev) ||
                     (EVENTS_IN.crc_fail && !EVENTS_IN.crc_static_seq); // R10
      invalid_ff <= (invalid_ff && !rd_dev) || EVENTS_IN.invalid_cmd; // R17 R18
      failure_ff <= (failure_ff && !rd_dev) || EVENTS_IN.device_fail; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data registered so it stands for the frame's answer
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RDATA_OUT <= tdsr_pkg::REG_RESET_VAL;
      RDATA_VALID_OUT <= 1'b0;
    end else begin
      RDATA_VALID_OUT <= rd_therm || rd_dev;
      if (rd_therm) begin
        RDATA_OUT <= {12'h000, therm_ff}; // R1
      end else if (rd_dev) begin
        RDATA_OUT <= {6'h00, // R8
                      CRC_ENABLED_IN, // R9
                      crc_fail_ff, prior_ff, 1'b0,
                      DEV_MODE_IN, // R14
                      wd_cnt, invalid_ff, failure_ff}; // R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb_main @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  a_prewarn_sticky: assert property ( // R5
    EVENTS_IN.prewarn && !soft_clr |=> therm_ff[0])
    else $error("prewarn not latched");
  a_level_one_set: assert property ( // R4
    EVENTS_IN.level_one && !soft_clr |=> therm_ff[1])
    else $error("level one not latched");
  a_level_two_set: assert property ( // R3
    EVENTS_IN.level_two && !soft_clr |=> therm_ff[2] && prior_ff == 2'h1)
    else $error("level two not latched");
  a_therm_hold: assert property ( // R6
    therm_ff[2] && !rd_therm && !soft_clr |=> therm_ff[2])
    else $error("thermal flag lost");
  a_upper_zero: assert property ( // R8
    RDATA_VALID_OUT |-> RDATA_OUT[15:10] == 6'h00)
    else $error("upper bits nonzero");
  a_soft_clear: assert property ( // R7
    soft_clr |=> therm_ff == 4'h0 && prior_ff == 2'h0)
    else $error("soft reset left flags");
  a_crc_static: assert property ( // R10
    !crc_fail_ff && EVENTS_IN.crc_static_seq |=> !crc_fail_ff)
    else $error("crc flag on static sequence");
  a_restart_code: assert property ( // R12
    restart_evt && !soft_clr |=> prior_ff == 2'h1)
    else $error("restart code missing");
  a_invalid_keep: assert property ( // R18
    invalid_ff && !rd_dev && !soft_clr |=> invalid_ff)
    else $error("invalid flag lost");
  a_dev_readout: assert property ( // R14
    rd_dev |=> RDATA_VALID_OUT && RDATA_OUT[4] == $past(DEV_MODE_IN))
    else $error("dev mode bit wrong");

endmodule : tdsr_status_regs

// >>> tdsr_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module tdsr_host_model (
  input wire logic clk_in,
  output tdsr_pkg::tdsr_access_t access_out,
  output logic crc_ok_out
);
  initial begin
    access_out = '0;
    crc_ok_out = 1'b1;
  end
  // One frame; serial reads clear flags, and device-information writes also clear the prior-mode field
  task automatic xfer(input logic wr, input logic [6:0] addr,
                      input logic [15:0] wdata, input logic ok);
    @(posedge clk_in);
    #1;
    access_out = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
    crc_ok_out = ok;
    @(posedge clk_in);
    #1;
    // Released frame shows junk, not the last value
    access_out = '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
    crc_ok_out = ~ok;
  endtask : xfer
endmodule : tdsr_host_model

// >>> test_thermal_and_device_status_regs.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module test_thermal_and_device_status_regs;
  localparam logic [6:0] A_TH = tdsr_pkg::THERMAL_EVENT_FLAGS_ADDR;
  localparam logic [6:0] A_DI = tdsr_pkg::DEVICE_INFORMATION_FLAGS_ADDR;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tdsr_pkg::tdsr_rst_t kind = tdsr_pkg::TDSR_RST_NONE;
  tdsr_pkg::tdsr_events_t ev = '0;
  tdsr_pkg::tdsr_events_t e;
  tdsr_pkg::tdsr_access_t acc;
  logic crc_ok;
  logic crc_en = 1'b0;
  logic dev_mode = 1'b0;
  logic [15:0] rdata;
  logic rvalid, reject, fs_req, mod_dis, long_wait;
  logic [15:0] lfsr = 16'h87dc;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int compares = 0;
  int rejects = 0;
  always #10 clk = ~clk;
  tdsr_host_model host_u (.clk_in(clk), .access_out(acc), .crc_ok_out(crc_ok));
  tdsr_status_regs dut_u (.CLK_IN(clk), .SYS_RST_IN(rst), .RST_KIND_IN(kind),
    .EVENTS_IN(ev), .ACCESS_IN(acc), .ACCESS_CRC_OK_IN(crc_ok),
    .CRC_ENABLED_IN(crc_en), .DEV_MODE_IN(dev_mode), .RDATA_OUT(rdata),
    .RDATA_VALID_OUT(rvalid), .ACCESS_REJECT_OUT(reject),
    .FAILSAFE_REQ_OUT(fs_req), .MODULE_DISABLE_OUT(mod_dis),
    .LONG_WAIT_OUT(long_wait));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("Compares %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  function automatic logic [15:0] info(input logic [15:0] v);
    return v | {6'h0, crc_en, 4'h0, dev_mode, 4'h0};
  endfunction : info
  task automatic rd(input logic [6:0] a, input logic [15:0] x,
                    input logic ok = 1'b1);
    exp_q.push_back(x);
    host_u.xfer(1'b0, a, 16'h0000, ok);
  endtask : rd
  task automatic pulse(input tdsr_pkg::tdsr_events_t p, input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      ev = p;
      #1;
      check({14'h0, fs_req, mod_dis}, {14'h0, p.level_two, p.level_one});
      @(posedge clk);
      #1;
      ev = '0;
    end
  endtask : pulse
  function automatic logic [15:0] nxt_lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt_lfsr
  task automatic levels();
    lfsr = nxt_lfsr(lfsr);
    @(posedge clk);
    #1;
    crc_en = lfsr[0];
    dev_mode = lfsr[1];
  endtask : levels
  ////////////////////////////////////////////////////////////////////////////
  // Scoreboard: every answer consumes the oldest note; mid-cycle, settled
  always @(negedge clk) begin
    if (reject === 1'b1)
      rejects++;
    if (rvalid === 1'b1) begin
      if (exp_q.size() > 0)
        check(rdata, exp_q.pop_front());
      else
        num_errors++;
    end
  end
  initial begin
    #1ms;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    levels();
    rd(A_TH, 16'h0000);
    rd(A_DI, info(16'h0000));
    e = '0;
    e.prewarn = 1'b1;
    e.level_one = 1'b1;
    e.level_two = 1'b1;
    pulse(e, 1);
    repeat (3) @(posedge clk);
    rd(A_TH, 16'h0007);
    rd(A_TH, 16'h0000);
    rd(A_DI, info(16'h0040));
    for (int k = 0; k < 4; k++) begin
      e = '0;
      e.logic_uv = (k == 0);
      e.failsafe_wake = (k == 1);
      e.sleep_no_wake = (k == 2);
      e.sleep_entry = (k == 3);
      levels();
      pulse(e, 1);
      rd(A_DI, info(k == 3 ? 16'h0080 : 16'h0040));
    end
    e = '0;
    e.crc_fail = 1'b1;
    e.invalid_cmd = 1'b1;
    e.device_fail = 1'b1;
    e.wd_expired = 1'b1;
    pulse(e, 1);
    e = '0;
    e.wd_expired = 1'b1;
    pulse(e, 3);
    rd(A_DI, info(16'h014f));
    rd(A_DI, info(16'h000c));
    e = '0;
    e.wd_clear = 1'b1;
    pulse(e, 1);
    e = '0;
    e.crc_static_seq = 1'b1;
    e.crc_fail = 1'b1;
    pulse(e, 1);
    rd(A_DI, info(16'h0000), 1'b0);
    host_u.xfer(1'b0, A_TH, 16'h0000, 1'b0);
    host_u.xfer(1'b0, 7'h43, 16'h0000, 1'b1);
    check(16'(rejects), 16'h0001);
    e = '0;
    e.logic_uv = 1'b1;
    e.prewarn = 1'b1;
    pulse(e, 1);
    host_u.xfer(1'b1, A_DI, lfsr, 1'b1);
    host_u.xfer(1'b1, A_TH, lfsr, 1'b1);
    rd(A_DI, info(16'h0000));
    rd(A_TH, 16'h0001);
    // Break the run of shutdowns so the count starts afresh
    e = '0;
    e.level_two_clear = 1'b1;
    pulse(e, 1);
    e = '0;
    e.level_two = 1'b1;
    pulse(e, tdsr_pkg::SAFE_STATE_EVENTS);
    check({15'h0, long_wait}, 16'h0000);
    rd(A_TH, 16'h0004);
    pulse(e, 1);
    check({15'h0, long_wait}, 16'h0001);
    rd(A_TH, 16'h000c);
    e = '0;
    e.prewarn = 1'b1;
    pulse(e, 1);
    kind = tdsr_pkg::TDSR_RST_RESTART;
    repeat (2) @(posedge clk);
    #1;
    kind = tdsr_pkg::TDSR_RST_NONE;
    rd(A_TH, 16'h0001);
    pulse(e, 1);
    kind = tdsr_pkg::TDSR_RST_POR;
    @(posedge clk);
    #1;
    kind = tdsr_pkg::TDSR_RST_NONE;
    check({15'h0, long_wait}, 16'h0000);
    rd(A_TH, 16'h0000);
    rd(A_DI, info(16'h0000));
    repeat (3) @(posedge clk);
    check(16'(exp_q.size()), 16'h0000);
    end_of_test();
  end
endmodule : test_thermal_and_device_status_regs
